// >>> occ_cfg.svh
`ifndef OCC_CFG_SVH
`define OCC_CFG_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OCC_OFF_CTRL     8'h00
`define OCC_OFF_STATUS   8'h04
`define OCC_OFF_LAMPS    8'h08
`define OCC_OFF_INDEX    8'h0C
`define OCC_OFF_ADDR     8'h10
`define OCC_OFF_ACC      8'h14
`define OCC_CTRL_LOCK    0
`define OCC_CTRL_RST     1'h0

// ----------------------------------------
// Status word positions (bit n at index 16-n)
// ----------------------------------------
`define OCC_ST_T1        15
`define OCC_ST_T2        14
`define OCC_ST_T3        13
`define OCC_ST_T4        12
`define OCC_ST_FETCH     11
`define OCC_ST_IND       10
`define OCC_ST_EXEC      9
`define OCC_ST_CARRY     8
`define OCC_ST_PI        7
`define OCC_ST_ML        5
`define OCC_ST_EA        4
`define OCC_ST_DP        3
`define OCC_ST_MPERR     1
`define OCC_ST_IOPERR    0

// ----------------------------------------
// Timing levels and opcodes
// ----------------------------------------
`define OCC_T_HALT       4'h4
`define OCC_T_FIRST      4'h1
`define OCC_OP_HALT      4'h0
`define OCC_OP_LDA       4'h1
`define OCC_OP_STA       4'h2
`define OCC_OP_ADD       4'h3
`define OCC_OP_JMP       4'h4
`define OCC_OP_MODE      4'h5
`define OCC_OP_IAB       4'h6
`define OCC_OP_CRA       4'h7

`endif

// >>> occ_console.sv
// Summary of operation
// R01 - Global clear zeroes A, B, M, P, Y, stops clock, halt timing state.
// R02 - Global clear leaves memory and index register untouched.
// R03 - Status word: timing levels bits 1-4, F 5, I 6, A 7, carry 8.
// R04 - Status bits 9 permit, 11 restricted, 12 extended, 13 double; 10, 14 unused.
// R05 - Status bit 15 memory parity error, bit 16 I/O parity error.
// R06 - Global clear resets all indicators except timing level 3 and fetch, set.
// R07 - Memory-access read: start loads addressed word into M for display.
// R08 - Increment set: each start reads next location; one press per location.
// R09 - Address register display shows last panel-accessed location at any time.
// R10 - Memory-access write: start stores entered M word at address.
// R11 - Increment set in write: each start stores same word at next location.
// R12 - Every write to location zero also loads index register; only way.
// R13 - Index select shows index register on indicators.
// R14 - First single-step start after clear fetches only, no execute.
// R15 - Later single-step starts execute, fetch next, bump P, then stop.
// R16 - After a step Y holds fetch address and P holds that plus one.
// R17 - Display maps register bits 1-16 to indicators 1-16, lit is one.
// R18 - Operator loads start address into P via address register select.
// R19 - Run start executes continuously until halt or mode set to single step.
// R20 - After stopping from run, restartable in run or single step.
// R21 - Selected register overwritten with entered data-bit value.
// R22 - Register-only instructions execute straight from M without memory access.
// R23 - Each button press synchronised, gives exactly one single-cycle pulse.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "occ_cfg.svh"

module occ_console
  import occ_pkg::*;
#(
  parameter int AW = 14
)
(
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic        HREADY,
  input  wire logic [31:0] HWDATA,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Panel controls
  input  wire logic        CLEAR_BTN,
  input  wire logic        START_BTN,
  input  wire logic        LOAD_BTN,
  input  wire logic [1:0]  MODE_SW,
  input  wire logic        STORE_SW,
  input  wire logic        INCR_SW,
  input  wire logic [2:0]  SEL_SW,
  input  wire logic [15:0] DATA_SW,
  // Option parity error lines
  input  wire logic        MEM_PERR,
  input  wire logic        IO_PERR,
  // Indicators
  output logic      [15:0] LAMPS,
  output logic             RUNNING
);

  localparam int NIN = 28;

  logic [NIN-1:0]   in_raw;
  logic [NIN-1:0]   s1_q, s2_q, s3_q, filt_q;
  logic [2:0]       btn_prev_q;
  logic [2:0]       btn_p;
  logic             lock_q;
  logic             clr_p, start_p, load_p;
  occ_sel_t         sel_sw;
  occ_mode_t        mode_sw;
  logic             running_q;
  logic [3:0]       t_q;
  occ_phase_t       phase_q;
  logic [15:0]      a_q, b_q, m_q, p_q, y_q, x_q;
  logic             c_q, pi_q, ml_q, ea_q, dp_q, mperr_q, ioperr_q;
  logic [15:0]      mem [2**AW];
  logic [15:0]      ma_addr;
  logic [AW-1:0]    eff_addr;
  logic             do_fetch, do_exec, halt_exec, start_run, ma_op;
  logic             mem_we;
  logic [AW-1:0]    mem_wa;
  logic [15:0]      mem_wd;
  logic [16:0]      sum;
  logic [15:0]      status_w;
  logic [15:0]      lamps_q;
  logic             hready_q, wr_pend_q;
  logic [7:0]       addr_q;
  logic [31:0]      hrdata_q;

  function automatic logic is_halt(input logic [15:0] w);
    return w[15:12] == `OCC_OP_HALT;
  endfunction

  // ----------------------------------------
  // Panel input synchronisers
  // ----------------------------------------
  assign in_raw = {CLEAR_BTN, START_BTN, LOAD_BTN, MEM_PERR, IO_PERR, STORE_SW, INCR_SW,
                   MODE_SW, SEL_SW, DATA_SW};

  // A change counts only once stages two and three agree
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      filt_q <= '0;
    end
    else
    begin
      s1_q   <= in_raw;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q)); // [R23]
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      btn_prev_q <= '0;
    else
      btn_prev_q <= filt_q[27:25];
  end

  // Rising edge only, so a held button acts once
  assign btn_p   = filt_q[27:25] & ~btn_prev_q & {3{~lock_q}}; // [R23]
  assign clr_p   = btn_p[2];
  assign start_p = btn_p[1];
  assign load_p  = btn_p[0] & ~running_q;
  assign sel_sw  = occ_sel_t'(filt_q[18:16]);
  assign mode_sw = occ_mode_t'(filt_q[20:19]);

  // ----------------------------------------
  // Sequencing events
  // ----------------------------------------
  assign do_fetch  = running_q & t_q[3] & (phase_q == OCC_PH_F);
  assign do_exec   = running_q & t_q[3] & (phase_q == OCC_PH_A);
  assign halt_exec = do_exec & is_halt(m_q);
  assign start_run = start_p & ~running_q & (mode_sw != OCC_MODE_MA);
  assign ma_op     = start_p & ~running_q & (mode_sw == OCC_MODE_MA);
  assign ma_addr   = filt_q[21] ? y_q + 16'h0001 : y_q; // [R08] [R11]
  assign eff_addr  = AW'(m_q[11:0]);
  assign sum       = {1'b0, a_q} + {1'b0, mem[eff_addr]};

  // ----------------------------------------
  // Run and timing control
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      running_q <= 1'b0;
      t_q       <= `OCC_T_HALT;
      phase_q   <= OCC_PH_F;
    end
    else if (clr_p)
    begin
      running_q <= 1'b0; // [R01]
      t_q       <= `OCC_T_HALT; // [R01] [R06]
      phase_q   <= OCC_PH_F; // [R06]
    end
    else if (start_run)
    begin
      running_q <= 1'b1; // [R19] [R20]
      t_q       <= `OCC_T_FIRST;
    end
    else if (running_q)
    begin
      if (halt_exec)
      begin
        running_q <= 1'b0; // [R19]
        t_q       <= `OCC_T_HALT;
        phase_q   <= OCC_PH_F; // [R20]
      end
      else if (do_fetch)
      begin
        phase_q <= OCC_PH_A;
        // Step or mode change stops only after a whole fetch
        if (mode_sw != OCC_MODE_RUN)
        begin
          running_q <= 1'b0; // [R14] [R15] [R19]
          t_q       <= `OCC_T_HALT;
        end
        else
          t_q <= `OCC_T_FIRST;
      end
      else if (do_exec)
      begin
        phase_q <= OCC_PH_F; // [R15]
        t_q     <= `OCC_T_FIRST;
      end
      else
        t_q <= {t_q[2:0], t_q[3]};
    end
  end

  // ----------------------------------------
  // Mainframe registers
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      {a_q, b_q, m_q, p_q, y_q} <= '0;
      {c_q, pi_q, ml_q, ea_q, dp_q} <= '0;
    end
    else if (clr_p)
    begin
      {a_q, b_q, m_q, p_q, y_q} <= '0; // [R01]
      {c_q, pi_q, ml_q, ea_q, dp_q} <= '0; // [R06]
    end
    else if (load_p)
    begin
      case (sel_sw)
        OCC_SEL_A:  a_q <= filt_q[15:0]; // [R21]
        OCC_SEL_B:  b_q <= filt_q[15:0]; // [R21]
        OCC_SEL_M:  m_q <= filt_q[15:0]; // [R21]
        OCC_SEL_PY:
        begin
          p_q <= filt_q[15:0]; // [R18]
          y_q <= filt_q[15:0]; // [R07]
        end
        default: ;
      endcase
    end
    else if (ma_op)
    begin
      y_q <= ma_addr; // [R09]
      if (!filt_q[22])
        m_q <= mem[ma_addr[AW-1:0]]; // [R07] [R08]
    end
    else if (do_fetch)
    begin
      y_q <= p_q; // [R16]
      m_q <= mem[p_q[AW-1:0]]; // [R14] [R15]
      p_q <= p_q + 16'h0001; // [R15] [R16]
    end
    else if (do_exec)
    begin
      // Register-only kinds never touch memory, so M may hold a keyed word
      case (m_q[15:12])
        `OCC_OP_LDA:  a_q <= mem[eff_addr];
        `OCC_OP_ADD:
        begin
          a_q <= sum[15:0];
          c_q <= (a_q[15] == mem[eff_addr][15]) && (sum[15] != a_q[15]);
        end
        `OCC_OP_JMP:  p_q <= 16'(m_q[11:0]);
        `OCC_OP_MODE: {pi_q, ml_q, ea_q, dp_q} <= m_q[3:0]; // [R22]
        `OCC_OP_IAB:
        begin
          a_q <= b_q; // [R22]
          b_q <= a_q;
        end
        `OCC_OP_CRA:  a_q <= 16'h0000; // [R22]
        default: ;
      endcase
    end
  end

  // Sticky parity flags; a new error beats a clear
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      mperr_q  <= 1'b0;
      ioperr_q <= 1'b0;
    end
    else
    begin
      mperr_q  <= (mperr_q & ~clr_p) | filt_q[24]; // [R05] [R06]
      ioperr_q <= (ioperr_q & ~clr_p) | filt_q[23]; // [R05] [R06]
    end
  end

  // ----------------------------------------
  // Memory and index mirror
  // ----------------------------------------
  assign mem_we = (ma_op & filt_q[22]) | (do_exec & (m_q[15:12] == `OCC_OP_STA));
  assign mem_wa = ma_op ? ma_addr[AW-1:0] : eff_addr;
  assign mem_wd = ma_op ? m_q : a_q; // [R10] [R11]

  // No reset on the array, so a clear never disturbs memory
  always_ff @(posedge REF_CLK)
  begin
    if (mem_we)
      mem[mem_wa] <= mem_wd; // [R02] [R10]
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      x_q <= 16'h0000;
    else if (mem_we && (mem_wa == '0))
      x_q <= mem_wd; // [R12] [R02]
  end

  // ----------------------------------------
  // Status word and indicators
  // ----------------------------------------
  always_comb
  begin
    status_w                   = 16'h0000; // [R04]
    status_w[`OCC_ST_T1]       = t_q[0]; // [R03]
    status_w[`OCC_ST_T2]       = t_q[1];
    status_w[`OCC_ST_T3]       = t_q[2];
    status_w[`OCC_ST_T4]       = t_q[3];
    status_w[`OCC_ST_FETCH]    = (phase_q == OCC_PH_F); // [R03]
    status_w[`OCC_ST_IND]      = (phase_q == OCC_PH_I);
    status_w[`OCC_ST_EXEC]     = (phase_q == OCC_PH_A);
    status_w[`OCC_ST_CARRY]    = c_q;
    status_w[`OCC_ST_PI]       = pi_q; // [R04]
    status_w[`OCC_ST_ML]       = ml_q;
    status_w[`OCC_ST_EA]       = ea_q;
    status_w[`OCC_ST_DP]       = dp_q;
    status_w[`OCC_ST_MPERR]    = mperr_q; // [R05]
    status_w[`OCC_ST_IOPERR]   = ioperr_q;
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      lamps_q <= 16'h0000;
    else
      case (sel_sw)
        OCC_SEL_X:  lamps_q <= x_q; // [R13] [R17]
        OCC_SEL_A:  lamps_q <= a_q; // [R17]
        OCC_SEL_B:  lamps_q <= b_q;
        OCC_SEL_OP: lamps_q <= status_w; // [R03]
        OCC_SEL_PY: lamps_q <= y_q; // [R09]
        OCC_SEL_M:  lamps_q <= m_q;
        default:    lamps_q <= 16'h0000;
      endcase
  end

  assign LAMPS   = lamps_q;
  assign RUNNING = running_q;

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
      hrdata_q  <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_q <= HSEL & HREADY & HTRANS[1] & HWRITE;
      addr_q    <= HADDR[7:0];
      if (HSEL && HREADY && HTRANS[1] && !HWRITE)
        case (HADDR[7:0])
          `OCC_OFF_CTRL:   hrdata_q <= {31'h0, lock_q};
          `OCC_OFF_STATUS: hrdata_q <= {16'h0, status_w};
          `OCC_OFF_LAMPS:  hrdata_q <= {16'h0, lamps_q};
          `OCC_OFF_INDEX:  hrdata_q <= {16'h0, x_q};
          `OCC_OFF_ADDR:   hrdata_q <= {16'h0, y_q};
          `OCC_OFF_ACC:    hrdata_q <= {15'h0, running_q, a_q};
          default:         hrdata_q <= 32'h0000_0000;
        endcase
      else
        hrdata_q <= 32'h0000_0000;
    end
  end

  // Lock masks the clear, start and load buttons while software owns the machine
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      lock_q <= `OCC_CTRL_RST;
    else if (wr_pend_q && (addr_q == `OCC_OFF_CTRL))
      lock_q <= HWDATA[`OCC_CTRL_LOCK];
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      hready_q <= 1'b1;
      HRESP    <= 1'b0;
    end
    else
    begin
      hready_q <= 1'b1;
      HRESP    <= 1'b0;
    end
  end

  assign HREADYOUT = hready_q;
  assign HRDATA    = hrdata_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  sequence seq_step_start;
    start_run && (mode_sw == OCC_MODE_SI) && (phase_q == OCC_PH_A);
  endsequence

  sequence seq_first_fetch;
    start_run && (phase_q == OCC_PH_F);
  endsequence

  AST_CLEAR_HALTS: assert property (clr_p |=> !running_q && t_q == `OCC_T_HALT // [R01]
    && status_w[`OCC_ST_FETCH] && status_w[`OCC_ST_T3] && !status_w[`OCC_ST_CARRY])
    else $error("clear did not leave halt state");
  AST_CLEAR_ZEROS: assert property (clr_p |=> (a_q | b_q | m_q | p_q | y_q) == 16'h0000) // [R01]
    else $error("clear did not zero registers");
  AST_CLEAR_KEEPS_X: assert property (clr_p |=> $stable(x_q)) // [R02]
    else $error("clear changed index register");
  AST_X_MIRROR: assert property (mem_we && mem_wa == '0 |=> x_q == $past(mem_wd)) // [R12]
    else $error("location zero write not mirrored");
  AST_X_ONLY_LOC0: assert property (!$stable(x_q) |-> $past(mem_we && mem_wa == '0)) // [R12]
    else $error("index register changed without location zero write");
  AST_MA_READ: assert property (ma_op && !filt_q[22] |=> m_q == mem[y_q[AW-1:0]]) // [R07]
    else $error("memory access read wrong word");
  AST_MA_INCR: assert property (ma_op && filt_q[21] |=> y_q == $past(y_q) + 16'h0001) // [R08]
    else $error("address did not advance");
  AST_FETCH_PC: assert property (do_fetch |=> p_q == y_q + 16'h0001) // [R16]
    else $error("program counter not fetch address plus one");
  AST_FIRST_NO_EXEC: assert property (seq_first_fetch |=> $stable(a_q)[*4]) // [R14]
    else $error("first step executed an instruction");
  AST_STEP_STOPS: assert property (seq_step_start |=> running_q ##[7:8] !running_q) // [R15]
    else $error("single step did not stop");
  AST_HALT_STOPS: assert property (halt_exec |=> !running_q && phase_q == OCC_PH_F) // [R19]
    else $error("halt did not stop");
  AST_PULSE_ONE: assert property (start_p |=> !start_p) // [R23]
    else $error("start pulse longer than one cycle");
  AST_STATUS_SHOWN: assert property (sel_sw == OCC_SEL_OP |=> LAMPS == $past(status_w)) // [R03]
    else $error("status word not displayed");

endmodule

// >>> occ_console_test.sv
`timescale 1ns/1ps
`include "occ_cfg.svh"

module occ_console_test;
  import occ_pkg::*;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        REF_CLK  = 1'b0;
  logic        RST_N    = 1'b0;
  logic        HSEL     = 1'b0;
  logic [31:0] HADDR    = 32'h0;
  logic [1:0]  HTRANS   = 2'h0;
  logic        HWRITE   = 1'b0;
  logic [31:0] HWDATA   = 32'h0;
  logic [1:0]  MODE_SW  = 2'h0;
  logic        STORE_SW = 1'b0;
  logic        INCR_SW  = 1'b0;
  logic [2:0]  SEL_SW   = 3'h0;
  logic [15:0] DATA_SW  = 16'h0;
  logic        MEM_PERR = 1'b0;
  logic        IO_PERR  = 1'b0;
  wire  logic  HREADY;
  logic [31:0] HRDATA;
  logic        HREADYOUT;
  logic        HRESP;
  logic        CLEAR_BTN;
  logic        START_BTN;
  logic        LOAD_BTN;
  logic [15:0] LAMPS;
  logic        RUNNING;
  logic [31:0] rd;
  int          err_count = 0;
  int          checked   = 0;
  int          cycles    = 0;

  assign HREADY = HREADYOUT;
  always #10 REF_CLK = ~REF_CLK;

  occ_console #(.AW(8)) dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HREADY(HREADY), .HWDATA(HWDATA),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CLEAR_BTN(CLEAR_BTN),
    .START_BTN(START_BTN), .LOAD_BTN(LOAD_BTN), .MODE_SW(MODE_SW), .STORE_SW(STORE_SW),
    .INCR_SW(INCR_SW), .SEL_SW(SEL_SW), .DATA_SW(DATA_SW), .MEM_PERR(MEM_PERR),
    .IO_PERR(IO_PERR), .LAMPS(LAMPS), .RUNNING(RUNNING));

  occ_operator op (.clk(REF_CLK), .clear_btn(CLEAR_BTN), .start_btn(START_BTN),
    .load_btn(LOAD_BTN));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Far above the roughly one thousand cycles the tests need
  always @(posedge REF_CLK)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      err_count++;
      $display("[FAIL] %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    @(posedge REF_CLK);
    HSEL   <= 1'b1;
    HTRANS <= 2'h2;
    HADDR  <= {24'h0, a};
    HWRITE <= w;
    do @(posedge REF_CLK); while (HREADY !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge REF_CLK); while (HREADY !== 1'b1);
    r = HRDATA;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, rd);
    chk(rd, e);
  endtask

  task automatic sw(input occ_mode_t m, input logic st, input logic inc, input occ_sel_t s);
    @(posedge REF_CLK);
    MODE_SW  <= m;
    STORE_SW <= st;
    INCR_SW  <= inc;
    SEL_SW   <= s;
  endtask

  // Lamps are registered, so let the selection settle first
  task automatic lamp(input occ_sel_t s, input logic [15:0] e);
    @(posedge REF_CLK);
    SEL_SW <= s;
    repeat (6) @(posedge REF_CLK);
    chk({16'h0, LAMPS}, {16'h0, e});
  endtask

  task automatic ld(input occ_sel_t s, input logic [15:0] v);
    @(posedge REF_CLK);
    SEL_SW  <= s;
    DATA_SW <= v;
    op.press(2, 6);
  endtask

  task automatic idle();
    int n;
    n = 0;
    while (RUNNING !== 1'b0 && n < 2000)
    begin
      @(posedge REF_CLK);
      n++;
    end
    chk({31'h0, RUNNING}, 32'h0);
  endtask

  task automatic go();
    op.press(1, 6);
    idle();
  endtask

  task automatic dep(input logic [15:0] a, input logic [15:0] d);
    sw(OCC_MODE_MA, 1'b1, 1'b0, OCC_SEL_M);
    ld(OCC_SEL_PY, a);
    ld(OCC_SEL_M, d);
    go();
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdchk(`OCC_OFF_STATUS, 32'h2800);
    rdchk(8'h40, 32'h0);
    chk({31'h0, HRESP}, 32'h0);
    chk({31'h0, HREADYOUT}, 32'h1);
    $display("test reset done");
  endtask

  task automatic t_deposit();
    dep(16'h0, 16'hA5C3);
    rdchk(`OCC_OFF_INDEX, 32'hA5C3);
    sw(OCC_MODE_MA, 1'b1, 1'b1, OCC_SEL_M);
    go();
    rdchk(`OCC_OFF_ADDR, 32'h1);
    dep(16'h2, 16'h1234);
    rdchk(`OCC_OFF_INDEX, 32'hA5C3);
    $display("test deposit done");
  endtask

  task automatic t_clear();
    ld(OCC_SEL_A, 16'h7777);
    @(posedge REF_CLK);
    MEM_PERR <= 1'b1;
    IO_PERR  <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    MEM_PERR <= 1'b0;
    IO_PERR  <= 1'b0;
    // Sticky flags set only after the pin filter, a few cycles on
    repeat (4) @(posedge REF_CLK);
    ahb(1'b0, `OCC_OFF_STATUS, 32'h0, rd);
    chk({30'h0, rd[1:0]}, 32'h3);
    op.press(0, 6);
    lamp(OCC_SEL_A, 16'h0);
    lamp(OCC_SEL_M, 16'h0);
    lamp(OCC_SEL_PY, 16'h0);
    lamp(OCC_SEL_X, 16'hA5C3);
    lamp(OCC_SEL_OP, 16'h2800);
    $display("test clear done");
  endtask

  task automatic t_examine();
    sw(OCC_MODE_MA, 1'b0, 1'b0, OCC_SEL_M);
    ld(OCC_SEL_PY, 16'h0);
    go();
    lamp(OCC_SEL_M, 16'hA5C3);
    sw(OCC_MODE_MA, 1'b0, 1'b1, OCC_SEL_M);
    op.press(1, 20);
    idle();
    lamp(OCC_SEL_M, 16'hA5C3);
    lamp(OCC_SEL_PY, 16'h1);
    go();
    lamp(OCC_SEL_M, 16'h1234);
    lamp(OCC_SEL_PY, 16'h2);
    // Locked panel must swallow the press
    ahb(1'b1, `OCC_OFF_CTRL, 32'h1, rd);
    rdchk(`OCC_OFF_CTRL, 32'h1);
    go();
    lamp(OCC_SEL_PY, 16'h2);
    ahb(1'b1, `OCC_OFF_CTRL, 32'h0, rd);
    $display("test examine done");
  endtask

  task automatic t_step();
    dep(16'h4, 16'h7000);
    dep(16'h5, 16'h1002);
    dep(16'h6, 16'h0000);
    sw(OCC_MODE_SI, 1'b0, 1'b0, OCC_SEL_PY);
    op.press(0, 6);
    ld(OCC_SEL_PY, 16'h4);
    ld(OCC_SEL_A, 16'h0055);
    go();
    lamp(OCC_SEL_M, 16'h7000);
    lamp(OCC_SEL_A, 16'h0055);
    lamp(OCC_SEL_PY, 16'h4);
    lamp(OCC_SEL_OP, 16'h2200);
    go();
    lamp(OCC_SEL_A, 16'h0);
    lamp(OCC_SEL_M, 16'h1002);
    lamp(OCC_SEL_PY, 16'h5);
    go();
    lamp(OCC_SEL_A, 16'h1234);
    lamp(OCC_SEL_PY, 16'h6);
    $display("test step done");
  endtask

  task automatic t_run();
    dep(16'h8, 16'h3002);
    dep(16'h9, 16'h0000);
    dep(16'hA, 16'h7000);
    dep(16'hB, 16'h0000);
    dep(16'hC, 16'h400C);
    sw(OCC_MODE_RUN, 1'b0, 1'b0, OCC_SEL_A);
    op.press(0, 6);
    ld(OCC_SEL_PY, 16'h8);
    ld(OCC_SEL_A, 16'h7000);
    go();
    rdchk(`OCC_OFF_ACC, 32'h8234);
    ahb(1'b0, `OCC_OFF_STATUS, 32'h0, rd);
    chk({31'h0, rd[`OCC_ST_CARRY]}, 32'h1);
    go();
    rdchk(`OCC_OFF_ACC, 32'h0);
    ld(OCC_SEL_PY, 16'hC);
    op.press(1, 6);
    repeat (50) @(posedge REF_CLK);
    chk({31'h0, RUNNING}, 32'h1);
    sw(OCC_MODE_SI, 1'b0, 1'b0, OCC_SEL_A);
    idle();
    $display("test run done");
  endtask

  initial
  begin
    repeat (10) @(posedge REF_CLK);
    RST_N <= 1'b1;
    t_reset();
    t_deposit();
    t_clear();
    t_examine();
    t_step();
    t_run();
    end_sim();
  end
endmodule

// >>> occ_operator.sv
`timescale 1ns/1ps

// ----------------------------------------
// Operator at the panel pushbuttons
// ----------------------------------------
module occ_operator
(
  // Clock
  input  wire logic clk,
  // Pushbuttons
  output logic      clear_btn,
  output logic      start_btn,
  output logic      load_btn
);
  initial
  begin
    clear_btn = 1'b0;
    start_btn = 1'b0;
    load_btn  = 1'b0;
  end

  // One press per action; release long enough for the filter to rearm
  task automatic press(input int which, input int hold);
    @(posedge clk);
    if (which == 0) clear_btn <= 1'b1;
    else if (which == 1) start_btn <= 1'b1;
    else load_btn <= 1'b1;
    repeat (hold) @(posedge clk);
    clear_btn <= 1'b0;
    start_btn <= 1'b0;
    load_btn  <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
endmodule

// >>> occ_pkg.sv
package occ_pkg;

  // ----------------------------------------
  // Panel selections and machine phases
  // ----------------------------------------
  typedef enum logic [2:0] {OCC_SEL_X, OCC_SEL_A, OCC_SEL_B, OCC_SEL_OP, OCC_SEL_PY,
                            OCC_SEL_M} occ_sel_t;
  typedef enum logic [1:0] {OCC_MODE_MA, OCC_MODE_SI, OCC_MODE_RUN} occ_mode_t;
  typedef enum logic [1:0] {OCC_PH_F, OCC_PH_I, OCC_PH_A} occ_phase_t;

endpackage
